// File: verilog/ehb_pkg.sv
`default_nettype none
package ehb_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int CNT_W = 5;
	localparam int DIV_W = 16;
	localparam int WAIT_W = 8;
	localparam int REFR_W = 11;
	localparam int TXN_W = ADDR_W + DATA_W;
	localparam int SYNC_W = 10;
	localparam int SYNC_TE = 8;
	localparam int SYNC_RF = 9;
	localparam int ERR_WFULL = 0;
	localparam int ERR_RSTALL = 1;
	localparam int ERR_TOUT = 2;
	localparam int IRQ_TX = 0;
	localparam int IRQ_RX = 1;
	localparam int IRQ_ERR = 2;
	localparam logic [CNT_W-1:0] TX_LVL_EMPTY = 5'h01;
	localparam logic [CNT_W-1:0] TX_LVL_1_4 = 5'h04;
	localparam logic [CNT_W-1:0] TX_LVL_1_2 = 5'h08;
	localparam logic [CNT_W-1:0] TX_LVL_3_4 = 5'h0C;
	localparam logic [CNT_W-1:0] RX_LVL_1_8 = 5'h02;
	localparam logic [CNT_W-1:0] RX_LVL_1_4 = 5'h04;
	localparam logic [CNT_W-1:0] RX_LVL_1_2 = 5'h08;
	localparam logic [CNT_W-1:0] RX_LVL_3_4 = 5'h0C;
	localparam logic [CNT_W-1:0] RX_LVL_7_8 = 5'h0E;
	localparam logic [CNT_W-1:0] RX_LVL_FULL = 5'h10;
	localparam int T_RFC_NS = 70;
	localparam int BAND0_MHZ = 15;
	localparam int BAND1_MHZ = 30;
	localparam int BAND2_MHZ = 50;
	localparam int BAND3_MHZ = 100;
	localparam logic [3:0] RFC_CYC_B0 = 4'((T_RFC_NS * BAND0_MHZ + 999) / 1000);
	localparam logic [3:0] RFC_CYC_B1 = 4'((T_RFC_NS * BAND1_MHZ + 999) / 1000);
	localparam logic [3:0] RFC_CYC_B2 = 4'((T_RFC_NS * BAND2_MHZ + 999) / 1000);
	localparam logic [3:0] RFC_CYC_B3 = 4'((T_RFC_NS * BAND3_MHZ + 999) / 1000);
	localparam logic [4:0] SDRAM_AW_BASE = 5'h17;
	typedef enum logic [1:0] {
		muxed_addr_data_submode = 2'h0,
		split_addr_data_submode = 2'h1,
		sram_submode            = 2'h2,
		fifo_submode            = 2'h3
	} submode_e;
	typedef enum logic [1:0] {
		cs_single     = 2'h0,
		cs_latch      = 2'h1,
		cs_dual       = 2'h2,
		cs_latch_dual = 2'h3
	} cscfg_e;
	typedef enum logic [1:0] {
		mode_off           = 2'h0,
		byte_host_bus_mode = 2'h1,
		sdram_mode         = 2'h2,
		mode_rsvd          = 2'h3
	} mode_e;
	typedef enum logic [3:0] {
		st_idle   = 4'h1,
		st_hold   = 4'h2,
		st_addr   = 4'h4,
		st_strobe = 4'h8
	} bus_st_e;
	typedef struct packed {
		mode_e             mode;
		submode_e          sub;
		logic              use_te;
		logic              use_rf;
		logic              wr_hi;
		logic              rd_hi;
		logic [1:0]        wr_wait;
		logic [1:0]        rd_wait;
		logic              word;
		logic              dual;
		cscfg_e            cs;
		logic [WAIT_W-1:0] max_wait;
		logic [31:0]       div;
	} cfg_s;
	localparam cfg_s RST_CFG = '0;
endpackage
`default_nettype wire

// File: verilog/stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: verilog/hb_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module hb_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
)
(
	input  wire logic              i_ref_clk,
	input  wire logic              i_reset,
	stream_if.snk                  s_in,
	stream_if.src                  s_out,
	output logic [$clog2(DEPTH):0] o_count
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0]   count_q;
	wire logic     push;
	wire logic     pop;

	assign s_in.ready = count_q != (AW+1)'(DEPTH);
	assign s_out.valid = count_q != '0;
	assign s_out.data = mem[rd_ptr_q];
	assign push = s_in.valid & s_in.ready;
	assign pop = s_out.valid & s_out.ready;
	assign o_count = count_q;

	always_ff @(posedge i_ref_clk)
	begin
		if (push)
			mem[wr_ptr_q] <= s_in.data;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			wr_ptr_q <= wr_ptr_q + AW'(push);
			rd_ptr_q <= rd_ptr_q + AW'(pop);
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// File: verilog/ext_host_bus.sv
// Summary of operation
// - byte host bus runs muxed, split, SRAM-style or FIFO-style access.
// - FIFO access honours enabled external empty and full inputs.
// - write strobe active high when optioned, else low.
// - read strobe active high when optioned, else low.
// - zero to three write wait states; reset gives zero.
// - zero to three read wait states; reset gives zero.
// - word access puts the byte in its lane, else bits 7:0.
// - dual rate clocks select 1 from the upper divider.
// - pins form one select, latch, two selects, or latch plus two.
// - FIFO hold-off limited to max ticks; zero waits forever.
// - SDRAM timing follows the core frequency band.
// - low power puts the SDRAM in self refresh.
// - SDRAM size 64 to 512 megabit sets address width.
// - 11-bit refresh count in core clocks sets refresh interval.
// - divider zero steps every clock, else every ((d/2)+1)*2.
// - write refused by full FIFO raises error when enabled.
// - read that cannot start at once raises error when enabled.
// - transmit trigger: empty, 1/4, 1/2 or 3/4.
// - receive trigger: 1/8, 1/4, 1/2, 3/4, 7/8 or full.
// - transmit request while write FIFO is below trigger.
// - receive request while read FIFO reaches trigger.
// - transmit, receive and error interrupts each have an enable; all three error flags share one.
// - hold-off beyond max wait flags a timeout error.
`timescale 1ns/100ps
`default_nettype none
module ext_host_bus
(
	input wire logic                       i_ref_clk,
	input wire logic                       i_reset,
	input wire ehb_pkg::mode_e             i_mode,
	input wire ehb_pkg::submode_e          i_submode,
	input wire logic                       i_use_tx_empty,
	input wire logic                       i_use_rx_full,
	input wire logic                       i_write_strobe_high_opt,
	input wire logic                       i_read_strobe_high_opt,
	input wire logic [1:0]                 i_wr_wait,
	input wire logic [1:0]                 i_rd_wait,
	input wire logic                       i_word_access,
	input wire logic                       i_dual_rate,
	input wire ehb_pkg::cscfg_e            i_cs_cfg,
	input wire logic [ehb_pkg::WAIT_W-1:0] i_max_wait,
	input wire logic [31:0]                i_divider,
	input wire logic [1:0]                 i_sdram_band,
	input wire logic                       i_sdram_low_power,
	input wire logic [1:0]                 i_sdram_size,
	input wire logic [ehb_pkg::REFR_W-1:0] i_sdram_refresh,
	input wire logic                       i_write_full_err_en,
	input wire logic                       i_read_stall_err_en,
	input wire logic [1:0]                 i_tx_lvl,
	input wire logic [2:0]                 i_rx_lvl,
	input wire logic [2:0]                 i_irq_en,
	input wire logic [2:0]                 i_err_clear,
	input wire logic                       i_wr_valid,
	input wire logic [ehb_pkg::ADDR_W-1:0] i_wr_addr,
	input wire logic [ehb_pkg::DATA_W-1:0] i_wr_data,
	output logic                           o_wr_ready,
	input wire logic                       i_rd_req,
	input wire logic [ehb_pkg::ADDR_W-1:0] i_rd_addr,
	output logic                           o_rd_busy,
	output logic                           o_rd_valid,
	output logic [ehb_pkg::DATA_W-1:0]     o_rd_data,
	input wire logic                       i_rd_ready,
	output logic [ehb_pkg::CNT_W-1:0]      o_tx_count,
	output logic [ehb_pkg::CNT_W-1:0]      o_rx_count,
	output logic [ehb_pkg::BYTE_W-1:0]     o_ad_out,
	output logic                           o_ad_oe,
	input wire logic [ehb_pkg::BYTE_W-1:0] i_ad_in,
	output logic [ehb_pkg::ADDR_W-1:0]     o_addr,
	output logic                           o_ctl_a,
	output logic                           o_ctl_b,
	output logic                           o_ctl_c,
	output logic                           o_wr_strobe,
	output logic                           o_rd_strobe,
	input wire logic                       i_ext_fifo_tx_empty_in,
	input wire logic                       i_ext_fifo_rx_full_in,
	output logic                           o_sdram_cke,
	output logic                           o_sdram_refresh,
	output logic [4:0]                     o_sdram_addr_width,
	output logic [3:0]                     o_sdram_rfc_cycles,
	output logic                           o_tx_request_irq,
	output logic                           o_rx_request_irq,
	output logic [2:0]                     o_err_flags,
	output logic                           o_irq
);
	localparam int AW = ehb_pkg::ADDR_W;
	localparam int DW = ehb_pkg::DATA_W;
	localparam int BW = ehb_pkg::BYTE_W;
	localparam int CW = ehb_pkg::CNT_W;
	localparam int VW = ehb_pkg::DIV_W;

	stream_if #(.W(ehb_pkg::TXN_W)) tx_in ();
	stream_if #(.W(ehb_pkg::TXN_W)) tx_out ();
	stream_if #(.W(DW))             rx_in ();
	stream_if #(.W(DW))             rx_out ();

	ehb_pkg::cfg_s    cfg_in;
	ehb_pkg::cfg_s    cfg_q;
	ehb_pkg::bus_st_e st_q;
	ehb_pkg::bus_st_e st_d;
	logic [VW-1:0]    tick_q;
	logic [VW-1:0]    div_act_q;
	logic [1:0]       wait_q;
	logic [ehb_pkg::WAIT_W-1:0] hold_q;
	logic             is_rd_q;
	logic             sel1_q;
	logic [AW-1:0]    addr_q;
	logic [BW-1:0]    wbyte_q;
	logic             rd_pend_q;
	logic [AW-1:0]    rd_addr_q;
	logic [ehb_pkg::SYNC_W-1:0] s1_q;
	logic [ehb_pkg::SYNC_W-1:0] s2_q;
	logic [ehb_pkg::SYNC_W-1:0] s3_q;
	logic [ehb_pkg::SYNC_W-1:0] filt_q;
	logic [ehb_pkg::REFR_W-1:0] refr_q;

	function automatic logic [VW-1:0] reload(input logic [VW-1:0] d);
		reload = (d == '0) ? '0 : {d[VW-1:1], 1'b1};
	endfunction

	hb_fifo #(.W(ehb_pkg::TXN_W), .DEPTH(ehb_pkg::FIFO_DEPTH)) u_tx_fifo
	(
		.i_ref_clk (i_ref_clk),
		.i_reset   (i_reset),
		.s_in      (tx_in),
		.s_out     (tx_out),
		.o_count   (o_tx_count)
	);

	hb_fifo #(.W(DW), .DEPTH(ehb_pkg::FIFO_DEPTH)) u_rx_fifo
	(
		.i_ref_clk (i_ref_clk),
		.i_reset   (i_reset),
		.s_in      (rx_in),
		.s_out     (rx_out),
		.o_count   (o_rx_count)
	);

	assign cfg_in = {i_mode, i_submode, i_use_tx_empty, i_use_rx_full,
		i_write_strobe_high_opt, i_read_strobe_high_opt, i_wr_wait, i_rd_wait,
		i_word_access, i_dual_rate, i_cs_cfg, i_max_wait, i_divider};

	wire logic          idle;
	wire logic          hb8_on;
	wire logic          fifo_sub;
	wire logic          te_s;
	wire logic          rf_s;
	wire logic          start_wr;
	wire logic          start_rd;
	wire logic          start;
	wire logic [AW-1:0] start_addr;
	wire logic          start_sel1;
	wire logic [VW-1:0] start_div;
	wire logic [DW-1:0] start_data;
	wire logic          need_ale;
	wire logic          gate_wr;
	wire logic          gate_rd;
	wire logic          gate_now;
	wire logic          gate_start;
	wire logic          tick;
	wire logic          timeout;
	wire logic          finish;
	wire logic [BW-1:0] rbyte;
	wire logic          tx_push;
	wire logic          tx_pop;
	wire logic [CW-1:0] tx_next;

	assign idle = st_q == ehb_pkg::st_idle;
	assign hb8_on = cfg_q.mode == ehb_pkg::byte_host_bus_mode;
	assign fifo_sub = cfg_q.sub == ehb_pkg::fifo_submode;
	assign te_s = filt_q[ehb_pkg::SYNC_TE];
	assign rf_s = filt_q[ehb_pkg::SYNC_RF];
	// writes drain ahead of a read so a read never overtakes queued data
	assign start_wr = idle & hb8_on & tx_out.valid;
	assign start_rd = idle & hb8_on & ~tx_out.valid & rd_pend_q & rx_in.ready;
	assign start = start_wr | start_rd;
	assign start_addr = start_wr ? tx_out.data[ehb_pkg::TXN_W-1:DW] : rd_addr_q;
	assign start_data = tx_out.data[DW-1:0];
	assign start_sel1 = start_addr[AW-1] & cfg_q.cs[1];
	assign start_div = (cfg_q.dual & start_sel1) ? cfg_q.div[31:16] : cfg_q.div[15:0];
	assign need_ale = ~fifo_sub
		& ((cfg_q.sub == ehb_pkg::muxed_addr_data_submode) | cfg_q.cs[0]);
	assign gate_wr = fifo_sub & cfg_q.use_rf & rf_s;
	assign gate_rd = fifo_sub & cfg_q.use_te & te_s;
	assign gate_now = is_rd_q ? gate_rd : gate_wr;
	assign gate_start = start_rd ? gate_rd : gate_wr;
	assign tick = tick_q == '0;
	assign timeout = (st_q == ehb_pkg::st_hold) & tick & gate_now
		& (cfg_q.max_wait != '0) & (hold_q == cfg_q.max_wait - 1'b1);
	assign finish = (st_q == ehb_pkg::st_strobe) & tick & (wait_q == 2'h0);
	assign rbyte = filt_q[BW-1:0];

	assign tx_push = i_wr_valid & o_wr_ready;
	assign tx_pop = start_wr;
	assign tx_in.valid = tx_push;
	assign tx_in.data = {i_wr_addr, i_wr_data};
	assign tx_out.ready = tx_pop;
	assign tx_next = o_tx_count + CW'(tx_push) - CW'(tx_pop);

	assign rx_in.valid = finish & is_rd_q;
	assign rx_in.data = cfg_q.word ? (DW'(rbyte) << {addr_q[1:0], 3'h0}) : DW'(rbyte);
	assign rx_out.ready = ~o_rd_valid | i_rd_ready;

	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			ehb_pkg::st_idle:
				if (start)
					st_d = gate_start ? ehb_pkg::st_hold
						: (need_ale ? ehb_pkg::st_addr : ehb_pkg::st_strobe);
			ehb_pkg::st_hold:
				if (timeout)
					st_d = ehb_pkg::st_idle;
				else if (tick & ~gate_now)
					st_d = ehb_pkg::st_strobe;
			ehb_pkg::st_addr:
				if (tick)
					st_d = ehb_pkg::st_strobe;
			ehb_pkg::st_strobe:
				if (finish)
					st_d = ehb_pkg::st_idle;
			default:
				st_d = ehb_pkg::st_idle;
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			st_q <= ehb_pkg::st_idle;
			cfg_q <= ehb_pkg::RST_CFG;
		end
		else
		begin
			st_q <= st_d;
			if (idle & ~start)
				cfg_q <= cfg_in;
		end
	end

	// one step per interface clock period
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			tick_q <= '0;
		else if (start)
			tick_q <= reload(start_div);
		else if (idle)
			tick_q <= '0;
		else
			tick_q <= tick ? reload(div_act_q) : tick_q - 1'b1;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			div_act_q <= '0;
			is_rd_q <= 1'b0;
			sel1_q <= 1'b0;
			addr_q <= '0;
			wbyte_q <= '0;
		end
		else if (start)
		begin
			div_act_q <= start_div;
			is_rd_q <= start_rd;
			sel1_q <= start_sel1;
			addr_q <= start_addr;
			wbyte_q <= cfg_q.word ? start_data[start_addr[1:0]*BW +: BW]
				: start_data[BW-1:0];
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			wait_q <= 2'h0;
		else if (start)
			wait_q <= start_rd ? cfg_q.rd_wait : cfg_q.wr_wait;
		else if ((st_q == ehb_pkg::st_strobe) & tick & (wait_q != 2'h0))
			wait_q <= wait_q - 2'h1;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset | start)
			hold_q <= '0;
		else if ((st_q == ehb_pkg::st_hold) & tick & gate_now)
			hold_q <= hold_q + 1'b1;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			rd_pend_q <= 1'b0;
			rd_addr_q <= '0;
		end
		else if (i_rd_req & ~rd_pend_q)
		begin
			rd_pend_q <= 1'b1;
			rd_addr_q <= i_rd_addr;
		end
		else if (is_rd_q & (finish | timeout))
			rd_pend_q <= 1'b0;
	end

	// a bit moves once stages two and three agree
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			filt_q <= '0;
		end
		else
		begin
			s1_q <= {i_ext_fifo_rx_full_in, i_ext_fifo_tx_empty_in, i_ad_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
		end
	end

	wire logic ale_on;
	wire logic stb_on;
	wire logic busy;
	wire logic cs0_n;
	wire logic cs1_n;
	wire logic ctl_a;
	wire logic ctl_b;
	wire logic ctl_c;

	assign ale_on = st_q == ehb_pkg::st_addr;
	assign stb_on = st_q == ehb_pkg::st_strobe;
	assign busy = ~idle;
	assign cs0_n = ~(busy & ~sel1_q);
	assign cs1_n = ~(busy & sel1_q);
	assign ctl_a = cfg_q.cs[0] ? ale_on
		: ((cfg_q.cs == ehb_pkg::cs_dual) ? cs0_n : ~busy);
	assign ctl_b = (cfg_q.cs == ehb_pkg::cs_dual) ? cs1_n
		: ((cfg_q.cs == ehb_pkg::cs_latch_dual) ? cs0_n : 1'b1);
	assign ctl_c = (cfg_q.cs == ehb_pkg::cs_latch_dual) ? cs1_n : 1'b1;

	// pins lag the state by one clock; every phase lasts at least one clock
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			o_ad_out <= '0;
			o_ad_oe <= 1'b0;
			o_addr <= '0;
			o_ctl_a <= 1'b1;
			o_ctl_b <= 1'b1;
			o_ctl_c <= 1'b1;
			o_wr_strobe <= 1'b1;
			o_rd_strobe <= 1'b1;
		end
		else
		begin
			o_ad_out <= ale_on ? addr_q[BW-1:0] : wbyte_q;
			o_ad_oe <= ale_on | (stb_on & ~is_rd_q);
			o_addr <= fifo_sub ? '0 : addr_q;
			o_ctl_a <= ctl_a;
			o_ctl_b <= ctl_b;
			o_ctl_c <= ctl_c;
			o_wr_strobe <= (stb_on & ~is_rd_q) ^ ~cfg_q.wr_hi;
			o_rd_strobe <= (stb_on & is_rd_q) ^ ~cfg_q.rd_hi;
		end
	end

	// user side
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			o_wr_ready <= 1'b1;
			o_rd_busy <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_data <= '0;
		end
		else
		begin
			o_wr_ready <= tx_next != CW'(ehb_pkg::FIFO_DEPTH);
			o_rd_busy <= (i_rd_req | rd_pend_q) & ~(is_rd_q & (finish | timeout));
			o_rd_valid <= rx_out.valid | (o_rd_valid & ~i_rd_ready);
			if (rx_out.valid & rx_out.ready)
				o_rd_data <= rx_out.data;
		end
	end

	wire logic [CW-1:0] tx_thr;
	wire logic [CW-1:0] rx_thr;
	wire logic          tx_req;
	wire logic          rx_req;
	wire logic [2:0]    err_ev;

	assign tx_thr = (i_tx_lvl == 2'h0) ? ehb_pkg::TX_LVL_EMPTY
		: (i_tx_lvl == 2'h1) ? ehb_pkg::TX_LVL_1_4
		: (i_tx_lvl == 2'h2) ? ehb_pkg::TX_LVL_1_2 : ehb_pkg::TX_LVL_3_4;
	assign rx_thr = (i_rx_lvl == 3'h0) ? ehb_pkg::RX_LVL_1_8
		: (i_rx_lvl == 3'h1) ? ehb_pkg::RX_LVL_1_4
		: (i_rx_lvl == 3'h2) ? ehb_pkg::RX_LVL_1_2
		: (i_rx_lvl == 3'h3) ? ehb_pkg::RX_LVL_3_4
		: (i_rx_lvl == 3'h4) ? ehb_pkg::RX_LVL_7_8 : ehb_pkg::RX_LVL_FULL;
	assign tx_req = o_tx_count < tx_thr;
	assign rx_req = o_rx_count >= rx_thr;
	assign err_ev[ehb_pkg::ERR_WFULL] = i_write_full_err_en & i_wr_valid & ~o_wr_ready;
	assign err_ev[ehb_pkg::ERR_RSTALL] = i_read_stall_err_en & i_rd_req & ~rd_pend_q
		& (busy | tx_out.valid | ~rx_in.ready | ~hb8_on);
	assign err_ev[ehb_pkg::ERR_TOUT] = timeout;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			o_tx_request_irq <= 1'b0;
			o_rx_request_irq <= 1'b0;
			o_err_flags <= 3'h0;
			o_irq <= 1'b0;
		end
		else
		begin
			o_tx_request_irq <= tx_req;
			o_rx_request_irq <= rx_req;
			// a new event outranks a clear arriving in the same cycle
			o_err_flags <= (o_err_flags & ~i_err_clear) | err_ev;
			o_irq <= (i_irq_en[ehb_pkg::IRQ_TX] & o_tx_request_irq)
				| (i_irq_en[ehb_pkg::IRQ_RX] & o_rx_request_irq)
				| (i_irq_en[ehb_pkg::IRQ_ERR] & (|o_err_flags));
		end
	end

	// sdram operating parameters
	wire logic sd_on;
	wire logic refr_run;

	assign sd_on = cfg_q.mode == ehb_pkg::sdram_mode;
	assign refr_run = sd_on & ~i_sdram_low_power & (i_sdram_refresh != '0);

	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			refr_q <= '0;
			o_sdram_refresh <= 1'b0;
			o_sdram_cke <= 1'b1;
			o_sdram_addr_width <= ehb_pkg::SDRAM_AW_BASE;
			o_sdram_rfc_cycles <= ehb_pkg::RFC_CYC_B0;
		end
		else
		begin
			refr_q <= (~refr_run | (refr_q == i_sdram_refresh - 1'b1)) ? '0 : refr_q + 1'b1;
			o_sdram_refresh <= refr_run & (refr_q == i_sdram_refresh - 1'b1);
			o_sdram_cke <= ~(sd_on & i_sdram_low_power);
			o_sdram_addr_width <= ehb_pkg::SDRAM_AW_BASE + 5'(i_sdram_size);
			o_sdram_rfc_cycles <= (i_sdram_band == 2'h0) ? ehb_pkg::RFC_CYC_B0
				: (i_sdram_band == 2'h1) ? ehb_pkg::RFC_CYC_B1
				: (i_sdram_band == 2'h2) ? ehb_pkg::RFC_CYC_B2 : ehb_pkg::RFC_CYC_B3;
		end
	end
endmodule
`default_nettype wire

// File: sim/ext_host_bus_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module ext_host_bus_assertions
(
	input wire logic           i_ref_clk,
	input wire logic           i_reset,
	input wire logic           i_wr_valid,
	input wire logic           o_wr_ready,
	input wire logic [4:0]     o_tx_count,
	input wire logic           i_write_full_err_en,
	input wire logic [2:0]     o_err_flags,
	input wire logic [2:0]     i_err_clear,
	input wire logic [2:0]     i_irq_en,
	input wire logic           o_irq,
	input wire ehb_pkg::mode_e i_mode,
	input wire logic           i_sdram_low_power,
	input wire logic           o_sdram_cke,
	input wire logic           o_sdram_refresh,
	input wire logic [10:0]    i_sdram_refresh,
	input wire logic [1:0]     i_sdram_size,
	input wire logic [4:0]     o_sdram_addr_width
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	sequence s_low_power;
		(i_sdram_low_power && i_mode == ehb_pkg::sdram_mode)[*4];
	endsequence
	property p_full_err;
		i_wr_valid && !o_wr_ready && i_write_full_err_en |-> ##[1:2] o_err_flags[0];
	endproperty
	property p_tx_full;
		o_tx_count == 5'h10 |-> !o_wr_ready;
	endproperty
	property p_err_sticky;
		o_err_flags[0] && !i_err_clear[0] |=> o_err_flags[0];
	endproperty
	property p_irq_mask;
		(i_irq_en == 3'h0)[*3] |-> !o_irq;
	endproperty
	property p_cke;
		s_low_power |-> !o_sdram_cke;
	endproperty
	property p_no_refresh;
		s_low_power |-> !o_sdram_refresh;
	endproperty
	property p_refresh_pulse;
		o_sdram_refresh && i_sdram_refresh > 11'h001 |=> !o_sdram_refresh;
	endproperty
	property p_width;
		$stable(i_sdram_size)[*3] |-> o_sdram_addr_width == 5'h17 + 5'(i_sdram_size);
	endproperty
	a_full_err: assert property (p_full_err) else $error("no full error");
	a_tx_full: assert property (p_tx_full) else $error("ready when full");
	a_err_sticky: assert property (p_err_sticky) else $error("flag lost");
	a_irq_mask: assert property (p_irq_mask) else $error("masked irq");
	a_cke: assert property (p_cke) else $error("cke high");
	a_no_refresh: assert property (p_no_refresh) else $error("refresh asleep");
	a_refresh_pulse: assert property (p_refresh_pulse) else $error("long refresh");
	a_width: assert property (p_width) else $error("bad width");
endmodule
bind ext_host_bus ext_host_bus_assertions u_chk (.i_ref_clk, .i_reset, .i_wr_valid, .o_wr_ready,
	.o_tx_count, .i_write_full_err_en, .o_err_flags, .i_err_clear, .i_irq_en, .o_irq, .i_mode,
	.i_sdram_low_power, .o_sdram_cke, .o_sdram_refresh, .i_sdram_refresh, .i_sdram_size,
	.o_sdram_addr_width);
`default_nettype wire

// File: sim/ext_bus_partner.sv
`timescale 1ns/100ps
`default_nettype none
module ext_bus_partner
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_wr_strobe,
	input  wire logic        i_rd_strobe,
	input  wire logic        i_wr_high,
	input  wire logic        i_rd_high,
	input  wire logic        i_oe,
	input  wire logic [7:0]  i_data,
	input  wire logic [19:0] i_addr,
	output logic [7:0]       o_data,
	output logic             o_tx_empty,
	output logic             o_rx_full
);
	logic [7:0] mem [256];
	logic [7:0] last_q;
	wire logic  wr_act = (i_wr_strobe == i_wr_high);
	wire logic  rd_act = (i_rd_strobe == i_rd_high);
	// released bus toggles so a stale byte never passes for read data
	assign o_data = rd_act ? mem[i_addr[7:0]] : ~last_q;
	assign o_tx_empty = 1'b0;
	assign o_rx_full = 1'b0;
	always_ff @(posedge i_ref_clk)
	begin
		last_q <= o_data;
		if (wr_act && i_oe)
			mem[i_addr[7:0]] <= i_data;
	end
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic              i_ref_clk, i_reset, i_use_tx_empty, i_use_rx_full, i_write_strobe_high_opt;
	logic              i_read_strobe_high_opt, i_word_access, i_dual_rate, i_sdram_low_power;
	logic              i_write_full_err_en, i_read_stall_err_en, i_wr_valid, i_rd_req, i_rd_ready;
	logic              o_wr_ready, o_rd_busy, o_rd_valid, o_ad_oe, o_ctl_a, o_ctl_b, o_ctl_c;
	logic              o_wr_strobe, o_rd_strobe, i_ext_fifo_tx_empty_in, i_ext_fifo_rx_full_in;
	logic              o_sdram_cke, o_sdram_refresh, o_tx_request_irq, o_rx_request_irq, o_irq;
	ehb_pkg::mode_e    i_mode;
	ehb_pkg::submode_e i_submode;
	ehb_pkg::cscfg_e   i_cs_cfg;
	logic [1:0]        i_wr_wait, i_rd_wait, i_sdram_band, i_sdram_size, i_tx_lvl;
	logic [2:0]        i_rx_lvl, i_irq_en, i_err_clear, o_err_flags;
	logic [7:0]        i_max_wait, i_ad_in, o_ad_out;
	logic [31:0]       i_divider, i_wr_data, o_rd_data, seed, r;
	logic [19:0]       i_wr_addr, i_rd_addr, o_addr;
	logic [10:0]       i_sdram_refresh;
	logic [4:0]        o_tx_count, o_rx_count, o_sdram_addr_width;
	logic [3:0]        o_sdram_rfc_cycles;
	logic [7:0]        mm [256];
	int                mismatches, check_count, n;
	int                mhz [4] = '{15, 30, 50, 100};
	ext_host_bus dut (.i_ref_clk, .i_reset, .i_mode, .i_submode, .i_use_tx_empty, .i_use_rx_full,
		.i_write_strobe_high_opt, .i_read_strobe_high_opt, .i_wr_wait, .i_rd_wait, .i_word_access,
		.i_dual_rate, .i_cs_cfg, .i_max_wait, .i_divider, .i_sdram_band, .i_sdram_low_power,
		.i_sdram_size, .i_sdram_refresh, .i_write_full_err_en, .i_read_stall_err_en, .i_tx_lvl,
		.i_rx_lvl, .i_irq_en, .i_err_clear, .i_wr_valid, .i_wr_addr, .i_wr_data, .o_wr_ready,
		.i_rd_req, .i_rd_addr, .o_rd_busy, .o_rd_valid, .o_rd_data, .i_rd_ready, .o_tx_count,
		.o_rx_count, .o_ad_out, .o_ad_oe, .i_ad_in, .o_addr, .o_ctl_a, .o_ctl_b, .o_ctl_c,
		.o_wr_strobe, .o_rd_strobe, .i_ext_fifo_tx_empty_in, .i_ext_fifo_rx_full_in, .o_sdram_cke,
		.o_sdram_refresh, .o_sdram_addr_width, .o_sdram_rfc_cycles, .o_tx_request_irq,
		.o_rx_request_irq, .o_err_flags, .o_irq);
	ext_bus_partner peer (.i_ref_clk, .i_wr_strobe(o_wr_strobe), .i_rd_strobe(o_rd_strobe),
		.i_wr_high(i_write_strobe_high_opt), .i_rd_high(i_read_strobe_high_opt), .i_oe(o_ad_oe),
		.i_data(o_ad_out), .i_addr(o_addr), .o_data(i_ad_in),
		.o_tx_empty(i_ext_fifo_tx_empty_in), .o_rx_full(i_ext_fifo_rx_full_in));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a);
		i_wr_addr = {12'h000, a};
		i_wr_data = xs();
		mm[a] = i_wr_data[7:0];
		i_wr_valid = 1'b1;
		while (o_wr_ready !== 1'b1)
			@(negedge i_ref_clk);
		@(negedge i_ref_clk);
	endtask
	task automatic rd(input logic [7:0] a);
		while (o_rd_busy !== 1'b0)
			@(negedge i_ref_clk);
		i_rd_addr = {12'h000, a};
		i_rd_req = 1'b1;
		@(negedge i_ref_clk);
		i_rd_req = 1'b0;
		while (o_rd_valid !== 1'b1)
			@(negedge i_ref_clk);
		chk("rdata", o_rd_data, {24'h000000, mm[a]});
		@(negedge i_ref_clk);
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	initial
	begin
		#100000;
		mismatches++;
		give_verdict();
	end
	initial
	begin
		seed = 32'h0000002D;
		r = xs();
		{i_reset, i_use_tx_empty, i_use_rx_full, i_word_access, i_dual_rate} = 5'h19;
		{i_write_strobe_high_opt, i_read_strobe_high_opt, i_wr_wait} = r[3:0];
		{i_max_wait, i_divider} = {r[11:4], r[31:16], 16'h0002};
		{i_mode, i_submode, i_cs_cfg} = {ehb_pkg::byte_host_bus_mode, ehb_pkg::sram_submode, ehb_pkg::cs_dual};
		{i_rd_wait, i_sdram_band, i_sdram_size, i_sdram_low_power} = 7'h60;
		{i_sdram_refresh, i_write_full_err_en, i_read_stall_err_en} = 13'h0017;
		{i_tx_lvl, i_rx_lvl, i_irq_en, i_err_clear} = 11'h620;
		{i_wr_valid, i_wr_addr, i_wr_data, i_rd_req, i_rd_addr, i_rd_ready} = 75'h1;
		repeat (10) @(negedge i_ref_clk);
		i_reset = 1'b0;
		repeat (3) @(negedge i_ref_clk);
		chk("idle", {o_wr_ready, o_ad_oe, o_ctl_a, o_ctl_b, o_ctl_c, o_err_flags}, 8'hB8);
		chk("wr idle", o_wr_strobe, !i_write_strobe_high_opt);
		chk("rd idle", o_rd_strobe, !i_read_strobe_high_opt);
		for (n = 0; n < 4; n++)
			wr(n[7:0]);
		i_wr_valid = 1'b0;
		for (n = 0; n < 4; n++)
			rd(n[7:0]);
		chk("stall", o_err_flags[1], 1'b1);
		i_mode = ehb_pkg::mode_off;
		for (n = 16; n < 32; n++)
			wr(n[7:0]);
		i_wr_addr = 20'h00020;
		repeat (2) @(negedge i_ref_clk);
		i_wr_valid = 1'b0;
		chk("full", {o_wr_ready, o_tx_count, o_tx_request_irq}, 7'h20);
		chk("full err", {o_err_flags[0], o_irq}, 2'h3);
		i_irq_en = 3'h0;
		i_err_clear = 3'h7;
		@(negedge i_ref_clk);
		i_err_clear = 3'h0;
		repeat (3) @(negedge i_ref_clk);
		chk("cleared", {o_err_flags, o_irq}, 4'h0);
		i_mode = ehb_pkg::byte_host_bus_mode;
		while (o_tx_count !== 5'h00)
			@(negedge i_ref_clk);
		@(negedge i_ref_clk);
		chk("requests", {o_tx_request_irq, o_rx_request_irq, o_rx_count}, 7'h40);
		for (n = 16; n < 32; n++)
			rd(n[7:0]);
		i_mode = ehb_pkg::sdram_mode;
		for (n = 0; n < 4; n++)
		begin
			i_sdram_band = n[1:0];
			i_sdram_size = n[1:0];
			repeat (3) @(negedge i_ref_clk);
			chk("rfc", o_sdram_rfc_cycles, (ehb_pkg::T_RFC_NS * mhz[n] + 999) / 1000);
			chk("width", o_sdram_addr_width, 23 + n);
		end
		while (o_sdram_refresh !== 1'b1)
			@(negedge i_ref_clk);
		n = 0;
		do
		begin
			@(negedge i_ref_clk);
			n++;
		end
		while (o_sdram_refresh !== 1'b1 && n < 50);
		chk("refresh", n, 5);
		i_sdram_low_power = 1'b1;
		repeat (4) @(negedge i_ref_clk);
		chk("cke", o_sdram_cke, 1'b0);
		give_verdict();
	end
endmodule
`default_nettype wire
